// [src/tmr8_ctrl_status.sv]
// Register core of the 8-bit timer: bus slave, counter, flags, outputs.
`timescale 1ns/1ps
module tmr8_ctrl_status (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic extCountPin,
   input wire logic globalIrqEn,
   input wire logic cmpBVecExec,
   input wire logic cmpAVecExec,
   input wire logic ovfVecExec,
   output logic waveOutA,
   output logic waveOutAEn,
   output logic waveOutB,
   output logic waveOutBEn,
   output logic cmpBIrq,
   output logic cmpAIrq,
   output logic ovfIrq
);
   // Register state.
   logic [7:0] ctrlAFf;
   logic [3:0] ctrlBFf;
   logic [7:0] cntFf;
   logic [7:0] cmpAFf;
   logic [7:0] cmpBFf;
   logic [2:0] maskFf;
   logic [2:0] flagsFf;
   logic [2:0] irqFf;
   logic blockFf;
   tmr8_pkg::tmr8_dir_type dirFf;
   logic wrPendFf;
   logic [7:0] wrIdxFf;
   logic [31:0] hrdataFf;
   logic readyFf;
   logic waveAFf;
   logic waveBFf;
   logic waveAEnFf;
   logic waveBEnFf;

   // Next values.
   logic [7:0] nxt_ctrlA;
   logic [3:0] nxt_ctrlB;
   logic [7:0] nxt_cnt;
   logic [7:0] nxt_cmpA;
   logic [7:0] nxt_cmpB;
   logic [2:0] nxt_mask;
   logic [2:0] nxt_flags;
   logic nxt_block;
   tmr8_pkg::tmr8_dir_type nxt_dir;
   logic nxt_waveA;
   logic nxt_waveB;
   logic [7:0] rdByte;

   tmr8_tick_if tickIf ();

   // Clock source selector with prescaler and pin synchroniser.
   tmr8_clk_select u_clk_select (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .clkEn (clkEn),
      .extCountPin (extCountPin),
      .tickIf (tickIf.sel)
   );

   // Matches a register index against a decoded target.
   function automatic logic regHit(input logic [7:0] idx,
                                   input logic [7:0] want);
      regHit = (idx == want);
   endfunction

   // Next level of a waveform output for its action field and mode.
   function automatic logic waveNext(input logic cur,
                                     input logic [1:0] com,
                                     input logic hit,
                                     input logic wrapEv,
                                     input logic down,
                                     input logic fast,
                                     input logic phase,
                                     input logic togOk);
      logic res;
      res = cur;
      if (!fast && !phase) begin
         if (hit && com == tmr8_pkg::COM_TOGGLE) begin
            res = ~cur;
         end else if (hit && com == tmr8_pkg::COM_CLEAR) begin
            res = 1'b0;
         end else if (hit && com == tmr8_pkg::COM_SET) begin
            res = 1'b1;
         end
      end else if (com == tmr8_pkg::COM_TOGGLE) begin
         if (hit && togOk) begin
            res = ~cur;
         end
      end else if (com != tmr8_pkg::COM_OFF) begin
         if (hit) begin
            res = (com == tmr8_pkg::COM_SET) ^ (phase & down);
         end else if (fast && wrapEv) begin
            res = (com == tmr8_pkg::COM_CLEAR);
         end
      end
      waveNext = res;
   endfunction

   // Bus address phase and the write decode for the data phase.
   wire addrAccept = hsel & htrans[1] & hready;
   wire [7:0] addrIdx = haddr[9:2];
   wire [7:0] wrByte = hwdata[7:0];
   wire wrCtrlA = wrPendFf & regHit(wrIdxFf, tmr8_pkg::CTRL_A_IDX);
   wire wrCtrlB = wrPendFf & regHit(wrIdxFf, tmr8_pkg::CTRL_B_IDX);
   wire wrCnt = wrPendFf & regHit(wrIdxFf, tmr8_pkg::CNT_IDX);
   wire wrCmpA = wrPendFf & regHit(wrIdxFf, tmr8_pkg::CMP_A_IDX);
   wire wrCmpB = wrPendFf & regHit(wrIdxFf, tmr8_pkg::CMP_B_IDX);
   wire wrMask = wrPendFf & regHit(wrIdxFf, tmr8_pkg::MASK_IDX);
   wire wrFlags = wrPendFf & regHit(wrIdxFf, tmr8_pkg::FLAG_IDX);

   // Mode decode from the two control registers.
   wire [2:0] waveMode = {ctrlBFf[tmr8_pkg::WAVE_HI_BIT],
                          ctrlAFf[1:0]}; // [RL21]
   wire isPwm = waveMode[0];
   wire isPhase = waveMode[0] & ~waveMode[1];
   wire isFast = waveMode[0] & waveMode[1];
   wire isCtc = (waveMode == tmr8_pkg::MODE_CTC);
   wire [7:0] topVal = (isCtc | (waveMode[2] & waveMode[0])) ?
                       cmpAFf : tmr8_pkg::CNT_MAX;
   wire atTop = (cntFf == topVal);
   wire atBottom = (cntFf == tmr8_pkg::CNT_BOTTOM);
   wire goingDown = (dirFf == tmr8_pkg::DIR_DOWN);
   wire [1:0] comA = ctrlAFf[tmr8_pkg::COM_A_LSB +: 2];
   wire [1:0] comB = ctrlAFf[tmr8_pkg::COM_B_LSB +: 2];
   assign tickIf.clockSourceSel = ctrlBFf[2:0]; // [RL8]
   wire tick = tickIf.tick;

   // Force strobes are taken only outside PWM modes, never stored.
   wire forceA = wrCtrlB & wrByte[tmr8_pkg::FOC_A_BIT] & ~isPwm;
   wire forceB = wrCtrlB & wrByte[tmr8_pkg::FOC_B_BIT] & ~isPwm; // [RL1]

   // Compare matches on a timer tick, blocked after a counter write.
   wire matchA = tick & ~blockFf & (cntFf == cmpAFf); // [RL13] [RL12]
   wire matchB = tick & ~blockFf & (cntFf == cmpBFf); // [RL14] [RL12]
   wire wrapEv = tick & atTop & isFast;
   wire ovfEv = tick & (isPhase ? (goingDown & atBottom) :
                (waveMode == tmr8_pkg::MODE_FPWM_TOP) ? atTop :
                (cntFf == tmr8_pkg::CNT_MAX)); // [RL20]

   // Flag events and their clears; forced matches stay out of here.
   wire [2:0] flagEv = {matchB, matchA, ovfEv}; // [RL4]
   wire [2:0] vecClr = {cmpBVecExec, cmpAVecExec, ovfVecExec};
   wire [2:0] flagClr = vecClr | ({3{wrFlags}} & wrByte[2:0]);

   // Register updates; reserved and strobe bits are never stored.
   assign nxt_ctrlA = wrCtrlA ? {wrByte[7:4], 2'h0, wrByte[1:0]} : ctrlAFf;
   assign nxt_ctrlB = wrCtrlB ? wrByte[3:0] : ctrlBFf; // [RL5] [RL6]
   assign nxt_cmpA = wrCmpA ? wrByte : cmpAFf;
   assign nxt_cmpB = wrCmpB ? wrByte : cmpBFf;
   assign nxt_mask = wrMask ? wrByte[2:0] : maskFf; // [RL6]
   assign nxt_block = wrCnt | (blockFf & ~tick); // [RL12]

   // Counter sequence; with no tick and no counter write the value simply holds.
   always_comb begin
      nxt_cnt = cntFf;
      nxt_dir = dirFf;
      if (wrCnt) begin
         nxt_cnt = wrByte; // [RL11]
      end else if (tick && isPhase) begin
         if (goingDown && !atBottom) begin
            nxt_cnt = cntFf - 8'h01;
         end else if (goingDown) begin
            nxt_cnt = cntFf + 8'h01;
            nxt_dir = tmr8_pkg::DIR_UP;
         end else if (atTop) begin
            nxt_cnt = cntFf - 8'h01;
            nxt_dir = tmr8_pkg::DIR_DOWN;
         end else begin
            nxt_cnt = cntFf + 8'h01;
         end
      end else if (tick) begin
         nxt_cnt = atTop ? tmr8_pkg::CNT_BOTTOM : cntFf + 8'h01; // [RL23]
         nxt_dir = tmr8_pkg::DIR_UP;
      end
   end

   // Waveform levels; a force uses the action field held right now.
   assign nxt_waveA = waveNext(waveAFf, comA, matchA | forceA, wrapEv,
                               goingDown, isFast, isPhase, waveMode[2]);
   assign nxt_waveB = waveNext(waveBFf, comB, matchB | forceB, wrapEv,
                               goingDown, isFast, isPhase,
                               1'b0); // [RL3] [RL22]

   // Read data taken from next values so a write just before is seen.
   always_comb begin
      if (regHit(addrIdx, tmr8_pkg::CTRL_A_IDX)) begin
         rdByte = nxt_ctrlA;
      end else if (regHit(addrIdx, tmr8_pkg::CTRL_B_IDX)) begin
         rdByte = {4'h0, nxt_ctrlB}; // [RL5] [RL6]
      end else if (regHit(addrIdx, tmr8_pkg::CNT_IDX)) begin
         rdByte = nxt_cnt; // [RL11]
      end else if (regHit(addrIdx, tmr8_pkg::CMP_A_IDX)) begin
         rdByte = nxt_cmpA;
      end else if (regHit(addrIdx, tmr8_pkg::CMP_B_IDX)) begin
         rdByte = nxt_cmpB;
      end else if (regHit(addrIdx, tmr8_pkg::MASK_IDX)) begin
         rdByte = {5'h00, nxt_mask}; // [RL6]
      end else if (regHit(addrIdx, tmr8_pkg::FLAG_IDX)) begin
         rdByte = {5'h00, nxt_flags}; // [RL7]
      end else begin
         rdByte = 8'h00;
      end
   end

   // Flags set on events and clear by vector or a written one.
   // An event in the clearing cycle wins so it is never lost.
   // Requests follow the flag gated by mask and global enable.
   for (genvar i = 0; i < 3; i++) begin : g_flag
      assign nxt_flags[i] = flagEv[i] |
                            (flagsFf[i] & ~flagClr[i]); // [RL18] [RL19] [RL20]
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            flagsFf[i] <= 1'b0;
            irqFf[i] <= 1'b0;
         end else if (clkEn) begin
            flagsFf[i] <= nxt_flags[i];
            irqFf[i] <= flagsFf[i] & maskFf[i] &
                        globalIrqEn; // [RL15] [RL16] [RL17]
         end
      end
   end

   // Bus slave state: zero wait states, always OKAY.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPendFf <= 1'b0;
         wrIdxFf <= 8'h00;
         hrdataFf <= 32'h0000_0000;
         readyFf <= 1'b1;
      end else if (clkEn) begin
         readyFf <= 1'b1;
         wrPendFf <= addrAccept & hwrite;
         wrIdxFf <= addrIdx;
         hrdataFf <= (addrAccept && !hwrite) ? {24'h00_0000, rdByte} :
                     32'h0000_0000;
      end
   end

   // Control, compare and mask registers.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlAFf <= tmr8_pkg::REG_RESET;
         ctrlBFf <= tmr8_pkg::REG_RESET[3:0];
         cmpAFf <= tmr8_pkg::REG_RESET;
         cmpBFf <= tmr8_pkg::REG_RESET;
         maskFf <= tmr8_pkg::REG_RESET[2:0];
      end else if (clkEn) begin
         ctrlAFf <= nxt_ctrlA;
         ctrlBFf <= nxt_ctrlB;
         cmpAFf <= nxt_cmpA;
         cmpBFf <= nxt_cmpB;
         maskFf <= nxt_mask;
      end
   end

   // Counter, direction and match blocking.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cntFf <= tmr8_pkg::REG_RESET;
         dirFf <= tmr8_pkg::DIR_UP;
         blockFf <= 1'b0;
      end else if (clkEn) begin
         cntFf <= nxt_cnt;
         dirFf <= nxt_dir;
         blockFf <= nxt_block;
      end
   end

   // Waveform levels and pin drive enables.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         waveAFf <= 1'b0;
         waveBFf <= 1'b0;
         waveAEnFf <= 1'b0;
         waveBEnFf <= 1'b0;
      end else if (clkEn) begin
         waveAFf <= nxt_waveA;
         waveBFf <= nxt_waveB;
         waveAEnFf <= (comA != tmr8_pkg::COM_OFF);
         waveBEnFf <= (comB != tmr8_pkg::COM_OFF);
      end
   end

   // Outputs straight from flip-flops, save hresp tied low.
   assign hreadyout = readyFf;
   assign hrdata = hrdataFf;
   assign hresp = 1'b0;
   assign waveOutA = waveAFf;
   assign waveOutB = waveBFf;
   assign waveOutAEn = waveAEnFf;
   assign waveOutBEn = waveBEnFf;
   assign cmpBIrq = irqFf[2];
   assign cmpAIrq = irqFf[1];
   assign ovfIrq = irqFf[0];

   // Checks on the behaviour above.
   a_ctrlb_reads_zero: assert property ( // [RL5]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && addrAccept && !hwrite &&
       addrIdx == tmr8_pkg::CTRL_B_IDX) |=> (hrdata[7:4] == 4'h0))
      else $error("Control B strobe or reserved bits read nonzero.");
   a_mask_rsvd_zero: assert property ( // [RL6]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && addrAccept && !hwrite &&
       addrIdx == tmr8_pkg::MASK_IDX) |=> (hrdata[31:3] == 29'h0))
      else $error("Mask reserved bits read nonzero.");
   a_flag_rsvd_zero: assert property ( // [RL7]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && addrAccept && !hwrite &&
       addrIdx == tmr8_pkg::FLAG_IDX) |=> (hrdata[7:3] == 5'h00))
      else $error("Flag reserved bits read nonzero.");
   a_pwm_force_ignored: assert property ( // [RL1]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && wrCtrlB && hwdata[6] && isPwm && !tick)
      |=> (waveOutB == $past(waveOutB)))
      else $error("Force strobe acted in a PWM mode.");

   a_force_b_level: assert property ( // [RL3]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && forceB && comB == tmr8_pkg::COM_SET) |=> waveOutB)
      else $error("Forced match did not set output B.");

   a_force_no_flag: assert property ( // [RL4]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && forceB && !matchB && !flagsFf[2]) |=> !flagsFf[2])
      else $error("Forced match set the compare B flag.");

   a_div8_spacing: assert property ( // [RL8]
      @(posedge sys_clk) disable iff (!reset_n)
      (tick && ctrlBFf[2:0] == tmr8_pkg::CS_DIV8) |=> !tick [*7])
      else $error("Divide-by-8 tick came too early.");

   a_stop_holds: assert property ( // [RL23]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && ctrlBFf[2:0] == tmr8_pkg::CS_STOP && !wrCnt)
      |=> (cntFf == $past(cntFf)))
      else $error("Stopped counter changed.");

   a_cnt_write_value: assert property ( // [RL11]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && wrCnt) |=> (cntFf == $past(hwdata[7:0])))
      else $error("Counter write did not load the value.");

   a_cnt_write_block: assert property ( // [RL12]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && wrCnt) |=> (!matchA && !matchB))
      else $error("Match seen on the tick after a counter write.");

   a_match_a_flag: assert property ( // [RL19]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && matchA) |=> flagsFf[1])
      else $error("Compare A match did not set its flag.");

   a_ovf_request: assert property ( // [RL17]
      @(posedge sys_clk) disable iff (!reset_n)
      (clkEn && flagsFf[0] && maskFf[0] && globalIrqEn) |=> ovfIrq)
      else $error("Enabled overflow flag raised no request.");
endmodule // tmr8_ctrl_status

// [src/tmr8_pkg.sv]
// Constants and types of the 8-bit timer control and status block.
// Function
// RL1: Channel B force strobe acts only in non-PWM waveform modes.
// RL2: Software writes force strobes as zero while a PWM mode runs.
// RL3: Force B strobe makes an instant match using the current B action.
// RL4: Forced matches set no flag, raise no request, never clear counter.
// RL5: Force B bit is write-only and always reads as zero.
// RL6: Control B bits 5:4 and mask bits 7:3 always read zero.
// RL7: Flag register bits 7:3 always read zero.
// RL8: Source 0 stops; 1 undivided; 2..5 divide by 8, 64, 256, 1024.
// RL9: Sources 6 and 7 count falling and rising count-pin edges.
// RL10: Count pin edges count even while the pin acts as output.
// RL11: Counter register gives direct read and write of the counter.
// RL12: A counter write blocks any compare match on the next tick.
// RL13: Compare A value is matched against the counter continuously.
// RL14: Compare B value is matched against the counter continuously.
// RL15: Compare B request needs mask bit 2 and global enable.
// RL16: Compare A request needs mask bit 1 and global enable.
// RL17: Overflow request needs mask bit 0 and global enable.
// RL18: Flag 2 sets on B match, clears by vector or written one.
// RL19: Flag 1 sets on A match, clears by vector or written one.
// RL20: Flag 0 sets on overflow per mode, clears by vector or one.
// RL21: Waveform mode joins control B bit 3 with control A bits 1:0.
// RL22: Non-PWM B action: disconnected, toggle, clear or set on match.
// RL23: Source 0 holds the counter; counting resumes from that value.
package tmr8_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] CTRL_A_IDX = 8'h24;
   localparam logic [7:0] CTRL_B_IDX = 8'h25;
   localparam logic [7:0] CNT_IDX = 8'h26;
   localparam logic [7:0] CMP_A_IDX = 8'h27;
   localparam logic [7:0] CMP_B_IDX = 8'h28;
   localparam logic [7:0] MASK_IDX = 8'h29;
   localparam logic [7:0] FLAG_IDX = 8'h2a;
   // Reset value shared by all registers.
   localparam logic [7:0] REG_RESET = 8'h00;
   // Field positions.
   localparam int FOC_A_BIT = 7;
   localparam int FOC_B_BIT = 6;
   localparam int WAVE_HI_BIT = 3;
   localparam int COM_A_LSB = 6;
   localparam int COM_B_LSB = 4;
   localparam int CMP_B_POS = 2;
   localparam int CMP_A_POS = 1;
   localparam int OVF_POS = 0;
   // Clock source codes.
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   // Prescaler tap masks; a tap fires when all masked bits are one.
   localparam logic [9:0] PRE_M8 = 10'h007;
   localparam logic [9:0] PRE_M64 = 10'h03f;
   localparam logic [9:0] PRE_M256 = 10'h0ff;
   localparam logic [9:0] PRE_M1024 = 10'h3ff;
   // Output action codes and waveform modes.
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   localparam logic [2:0] MODE_CTC = 3'h2;
   localparam logic [2:0] MODE_FPWM_TOP = 3'h7;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   typedef enum logic {DIR_UP, DIR_DOWN} tmr8_dir_type;
endpackage

// [src/tmr8_tick_if.sv]
// Carrier between the register core and the clock source selector.
`timescale 1ns/1ps
interface tmr8_tick_if;
   logic [2:0] clockSourceSel;
   logic tick;
   modport core (output clockSourceSel, input tick);
   modport sel (input clockSourceSel, output tick);
endinterface

// [src/tmr8_clk_select.sv]
// Prescaler and count-pin edge detector producing the timer tick.
`timescale 1ns/1ps
module tmr8_clk_select (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic extCountPin,
   tmr8_tick_if.sel tickIf
);
   logic [9:0] preFf;
   logic [2:0] pinSyncFf;
   logic [2:0] sel;
   wire pinRise = pinSyncFf[1] & ~pinSyncFf[2];
   wire pinFall = ~pinSyncFf[1] & pinSyncFf[2];

   // Free-running prescaler and a pin synchroniser with an edge stage.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         preFf <= 10'h000;
         pinSyncFf <= 3'h0;
      end else if (clkEn) begin
         preFf <= preFf + 10'h001;
         pinSyncFf <= {pinSyncFf[1:0], extCountPin}; // [RL10]
      end
   end

   // Tap selection; code zero gives no tick so the counter holds.
   assign sel = tickIf.clockSourceSel;
   assign tickIf.tick = clkEn & (
      (sel == tmr8_pkg::CS_DIV1) |
      (sel == tmr8_pkg::CS_DIV8 &&
       (preFf & tmr8_pkg::PRE_M8) == tmr8_pkg::PRE_M8) |
      (sel == tmr8_pkg::CS_DIV64 &&
       (preFf & tmr8_pkg::PRE_M64) == tmr8_pkg::PRE_M64) |
      (sel == tmr8_pkg::CS_DIV256 &&
       (preFf & tmr8_pkg::PRE_M256) == tmr8_pkg::PRE_M256) |
      (sel == tmr8_pkg::CS_DIV1024 &&
       preFf == tmr8_pkg::PRE_M1024) |
      (sel == tmr8_pkg::CS_EXT_FALL && pinFall) |
      (sel == (tmr8_pkg::CS_EXT_FALL + 3'h1) && pinRise)); // [RL8] [RL9]

   a_ext_rise_tick: assert property (@(posedge sys_clk) // [RL9]
      disable iff (!reset_n)
      (clkEn && sel == 3'h7 && pinRise) |-> tickIf.tick)
      else $error("Rising pin edge gave no tick.");
endmodule // tmr8_clk_select

// [src/placeholder_none.sv]
// Intentionally empty companion; holds no logic.
`timescale 1ns/1ps

// [verif/tmr8_pin_model.sv]
// Model of the external source that drives the timer count pin.
`timescale 1ns/1ps
module tmr8_pin_model (
   input wire logic sys_clk,
   output logic extCountPin
);
   // The pin rests low until a scenario moves it.
   initial begin
      extCountPin = 1'b0;
   end

   // Changes the pin just after an edge and holds it for eight cycles.
   task automatic drive(input logic lvl);
      @(posedge sys_clk);
      extCountPin <= lvl;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule // tmr8_pin_model

// [verif/tb_timer8_ctrl_status_regs.sv]
// Self-checking bench for the 8-bit timer control and status block.
`timescale 1ns/1ps
module tb_timer8_ctrl_status_regs;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic globalIrqEn = 1'b0;
   logic [2:0] vecExec = 3'h0;
   logic clkEn = 1'b1;
   logic hreadyout, hresp, extCountPin, waveOutA, waveOutAEn;
   logic waveOutB, waveOutBEn, cmpBIrq, cmpAIrq, ovfIrq;
   logic [31:0] hrdata;
   logic [31:0] rd;
   int fail_count = 0;
   int checks_done = 0;

   // Free-running 100 MHz system clock.
   always #5 sys_clk = ~sys_clk;

   // The single slave answers its own ready, so hready is its hreadyout.
   tmr8_ctrl_status dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
      .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .extCountPin(extCountPin), .globalIrqEn(globalIrqEn),
      .cmpBVecExec(vecExec[2]), .cmpAVecExec(vecExec[1]),
      .ovfVecExec(vecExec[0]), .waveOutA(waveOutA),
      .waveOutAEn(waveOutAEn), .waveOutB(waveOutB),
      .waveOutBEn(waveOutBEn), .cmpBIrq(cmpBIrq), .cmpAIrq(cmpAIrq),
      .ovfIrq(ovfIrq));

   // Count pin source on the far side.
   tmr8_pin_model pin_u (.sys_clk(sys_clk), .extCountPin(extCountPin));

   // Prints the verdict and stops the run.
   task automatic end_of_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            want);
      end
   endtask

   // Waits for ready at a rising edge; a stuck bus ends the run.
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         end_of_test();
      end
   endtask

   // One single-word transfer; the byte address is four times the index.
   task automatic bus(input logic w, input logic [7:0] idx,
      input logic [7:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] want);
      bus(1'b0, idx, 8'h00);
      check(rd | {hresp, 31'h0}, want);
   endtask

   // Pulses the vector-executing inputs for one cycle.
   task automatic pulse(input logic [2:0] v);
      @(posedge sys_clk);
      vecExec <= v;
      @(posedge sys_clk);
      vecExec <= 3'h0;
   endtask

   // Reset values, read-back and reserved bits, unmapped place.
   task automatic t_regs();
      for (int i = 8'h24; i <= 8'h2b; i++) begin
         rdchk(8'(i), 32'h0);
      end
      wr(tmr8_pkg::CMP_A_IDX, 8'ha5);
      rdchk(tmr8_pkg::CMP_A_IDX, 32'ha5);
      wr(tmr8_pkg::CMP_B_IDX, 8'h5a);
      rdchk(tmr8_pkg::CMP_B_IDX, 32'h5a);
      wr(tmr8_pkg::MASK_IDX, 8'hff);
      rdchk(tmr8_pkg::MASK_IDX, 32'h07);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h78);
      rdchk(tmr8_pkg::CTRL_B_IDX, 32'h08);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h00);
      wr(tmr8_pkg::FLAG_IDX, 8'hf8);
      rdchk(tmr8_pkg::FLAG_IDX, 32'h0);
      wr(8'h2b, 8'hff);
      rdchk(8'h2b, 32'h0);
   endtask

   // Each internal source counts at its rate; a stopped timer holds.
   task automatic t_prescale();
      int m;
      int dv [5] = '{1, 8, 64, 256, 1024};
      logic [31:0] held;
      for (int k = 0; k < 5; k++) begin
         m = (k == 0) ? 40 : 4 * dv[k];
         wr(tmr8_pkg::CNT_IDX, 8'h00);
         wr(tmr8_pkg::CTRL_B_IDX, 8'(k + 1));
         repeat (m) @(posedge sys_clk);
         wr(tmr8_pkg::CTRL_B_IDX, 8'h00);
         bus(1'b0, tmr8_pkg::CNT_IDX, 8'h00);
         check(32'(rd >= m / dv[k] - 1 && rd <= m / dv[k] + 5), 32'h1);
         held = rd;
         repeat (30) @(posedge sys_clk);
         rdchk(tmr8_pkg::CNT_IDX, held);
      end
   endtask

   // Rising and falling pin edges count only under their own code.
   task automatic t_ext();
      wr(tmr8_pkg::CNT_IDX, 8'h00);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h07);
      pin_u.drive(1'b1);
      rdchk(tmr8_pkg::CNT_IDX, 32'h01);
      pin_u.drive(1'b0);
      rdchk(tmr8_pkg::CNT_IDX, 32'h01);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h06);
      pin_u.drive(1'b1);
      rdchk(tmr8_pkg::CNT_IDX, 32'h01);
      pin_u.drive(1'b0);
      rdchk(tmr8_pkg::CNT_IDX, 32'h02);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h00);
   endtask

   // Matches and overflow set flags; requests follow mask and enable.
   task automatic t_flags();
      wr(tmr8_pkg::CTRL_A_IDX, 8'hc0);
      wr(tmr8_pkg::FLAG_IDX, 8'hff);
      wr(tmr8_pkg::CMP_A_IDX, 8'h20);
      wr(tmr8_pkg::CMP_B_IDX, 8'h30);
      wr(tmr8_pkg::MASK_IDX, 8'h07);
      wr(tmr8_pkg::CNT_IDX, 8'h1c);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h01);
      repeat (300) @(posedge sys_clk);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h00);
      rdchk(tmr8_pkg::FLAG_IDX, 32'h07);
      check({30'h0, waveOutAEn, waveOutA}, 32'h3);
      check({29'h0, cmpBIrq, cmpAIrq, ovfIrq}, 32'h0);
      globalIrqEn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check({29'h0, cmpBIrq, cmpAIrq, ovfIrq}, 32'h7);
      wr(tmr8_pkg::MASK_IDX, 8'h05);
      repeat (3) @(posedge sys_clk);
      check({29'h0, cmpBIrq, cmpAIrq, ovfIrq}, 32'h5);
      wr(tmr8_pkg::FLAG_IDX, 8'h01);
      rdchk(tmr8_pkg::FLAG_IDX, 32'h06);
      pulse(3'h4);
      rdchk(tmr8_pkg::FLAG_IDX, 32'h02);
      pulse(3'h2);
      rdchk(tmr8_pkg::FLAG_IDX, 32'h00);
      globalIrqEn <= 1'b0;
   endtask

   // Forced B matches follow the action field and touch nothing else.
   task automatic t_force();
      logic [7:0] act [4] = '{8'h30, 8'h20, 8'h10, 8'h10};
      logic [31:0] want [4] = '{32'h1, 32'h0, 32'h1, 32'h0};
      for (int k = 0; k < 4; k++) begin
         wr(tmr8_pkg::CTRL_A_IDX, act[k]);
         wr(tmr8_pkg::CTRL_B_IDX, 8'h40);
         repeat (2) @(posedge sys_clk);
         #1;
         check({30'h0, waveOutBEn, waveOutB}, want[k] | 32'h2);
      end
      rdchk(tmr8_pkg::FLAG_IDX, 32'h0);
      wr(tmr8_pkg::CTRL_A_IDX, 8'h33);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h40);
      repeat (2) @(posedge sys_clk);
      #1;
      check({31'h0, waveOutB}, 32'h0);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h00);
      wr(tmr8_pkg::CTRL_A_IDX, 8'h22);
      wr(tmr8_pkg::CNT_IDX, 8'h05);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h40);
      rdchk(tmr8_pkg::CNT_IDX, 32'h05);
      rdchk(tmr8_pkg::FLAG_IDX, 32'h0);
      wr(tmr8_pkg::CTRL_A_IDX, 8'h00);
   endtask

   // A counter write equal to compare A must not flag on the next tick.
   task automatic t_block();
      wr(tmr8_pkg::FLAG_IDX, 8'hff);
      wr(tmr8_pkg::CMP_A_IDX, 8'h40);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h05);
      wr(tmr8_pkg::CNT_IDX, 8'h40);
      repeat (1100) @(posedge sys_clk);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h00);
      rdchk(tmr8_pkg::FLAG_IDX, 32'h0);
   endtask

   // A low clock enable freezes the running counter for twenty cycles.
   task automatic t_freeze();
      wr(tmr8_pkg::CNT_IDX, 8'h00);
      wr(tmr8_pkg::CTRL_B_IDX, 8'h01);
      clkEn <= 1'b0;
      repeat (20) @(posedge sys_clk);
      clkEn <= 1'b1;
      wr(tmr8_pkg::CTRL_B_IDX, 8'h00);
      rdchk(tmr8_pkg::CNT_IDX, 32'h03);
   endtask

   // Reset for five cycles, then the scenarios in turn.
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_regs();
      t_prescale();
      t_ext();
      t_flags();
      t_force();
      t_block();
      t_freeze();
      end_of_test();
   end
endmodule // tb_timer8_ctrl_status_regs
